// *** core/rate_mon_pkg.sv ***
// Purpose: Constants and code tables for the serial clock rate block.
// Assumes: Core clock of 200 MHz.
// Notes: Rate codes name a 48 kHz and a 44.1 kHz family member.
package rate_mon_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam logic [7:0] ADDR_MASTER_RATE_CONFIG = 8'h14;
  localparam logic [7:0] ADDR_MONITOR_STATUS = 8'h15;
  localparam logic [7:0] MASTER_RATE_CONFIG_RST = 8'h48;
  localparam logic [7:0] MONITOR_STATUS_RST = 8'hFF;
  localparam int RATE_MSB = 7;
  localparam int RATE_LSB = 4;
  localparam int RATIO_MSB = 3;
  localparam int RATIO_LSB = 0;
  localparam logic [3:0] CODE_INVALID = 4'hF;
  localparam logic [3:0] RATE_CODE_MAX = 4'h8;
  localparam logic [3:0] RATIO_CODE_MAX = 4'hC;
  localparam int ACC_W = 40;
  localparam logic [63:0] NCO_SCALE = (64'h1 << ACC_W) / CLK_HZ;
  localparam int TOL_PCT = 2;
  localparam int CNT_W = 16;
  localparam int RCNT_W = 12;

  function automatic int unsigned fs_hz(input logic [3:0] code,
                                        input logic fam44);
    int unsigned f48;
    int unsigned f44;
    f48 = 0;
    f44 = 0;
    unique case (code)
      4'h0: begin f48 = 8000; f44 = 7350; end
      4'h1: begin f48 = 16000; f44 = 14700; end
      4'h2: begin f48 = 24000; f44 = 22050; end
      4'h3: begin f48 = 32000; f44 = 29400; end
      4'h4: begin f48 = 48000; f44 = 44100; end
      4'h5: begin f48 = 96000; f44 = 88200; end
      4'h6: begin f48 = 192000; f44 = 176400; end
      4'h7: begin f48 = 384000; f44 = 352800; end
      4'h8: begin f48 = 768000; f44 = 705600; end
      default: begin f48 = 0; f44 = 0; end
    endcase
    return fam44 ? f44 : f48;
  endfunction

  function automatic logic [11:0] ratio_of(input logic [3:0] code);
    unique case (code)
      4'h0: return 12'h010;
      4'h1: return 12'h018;
      4'h2: return 12'h020;
      4'h3: return 12'h030;
      4'h4: return 12'h040;
      4'h5: return 12'h060;
      4'h6: return 12'h080;
      4'h7: return 12'h0C0;
      4'h8: return 12'h100;
      4'h9: return 12'h180;
      4'hA: return 12'h200;
      4'hB: return 12'h400;
      4'hC: return 12'h800;
      default: return 12'h000;
    endcase
  endfunction
endpackage

// *** core/rate_monitor.sv ***
// Purpose: Rate configuration registers, master clock generator, monitor.
// Assumes: Register port on the core clock; serial clocks from pins.
// Notes: Bit clocks above half the core clock cannot be produced.
// Operation
// - Rate field codes 0 to 8 name rate pairs 7.35/8 to 705.6/768 kHz.
// - Rate field resets to code 4, the 44.1/48 kHz pair.
// - Family bit in master mode: 0 picks 48 kHz, 1 picks 44.1 kHz.
// - Ratio field codes 0 to 12 give 16 to 2048 bit clocks per frame.
// - Both programmed fields are ignored in slave auto clock mode.
// - Master select 1 generates bit clock and frame sync; 0 takes them in.
// - Detected rate reads codes 0 to 8, or 15 when invalid.
// - Detected ratio reads codes 0 to 12, or 15 when invalid.
// - Both detected fields reset to all ones.
// - Config register resets to 0x48 and is read and write.
`timescale 1ns/1ps
module rate_monitor #(
  parameter logic [15:0] FRAME_TIMEOUT = 16'hFFFF
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic master_select,
  input wire logic rate_family_select,
  input wire logic auto_clk_cfg_off,
  input wire logic bclk_in,
  output logic bclk_out,
  output logic bclk_oe_n,
  input wire logic fsync_in,
  output logic fsync_out,
  output logic fsync_oe_n
);
  logic [7:0] cfg_ff, nxt_cfg;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [3:0] det_rate_ff, nxt_det_rate;
  logic [3:0] det_ratio_ff, nxt_det_ratio;
  logic [rate_mon_pkg::ACC_W-1:0] acc_ff, nxt_acc;
  logic [11:0] gcnt_ff, nxt_gcnt;
  logic fs_gen_ff, nxt_fs_gen;
  logic oe_n_ff, nxt_oe_n;
  logic [2:0] bsync_ff, fsync_ff;
  logic [rate_mon_pkg::CNT_W-1:0] cyc_ff, nxt_cyc;
  logic [rate_mon_pkg::RCNT_W-1:0] bcnt_ff, nxt_bcnt;
  logic armed_ff, nxt_armed;
  logic gen_en, b_mon, b_mon_d, f_mon, f_mon_d;
  logic [3:0] prog_rate, prog_ratio;
  logic [63:0] inc64;

  // Period window for a rate code, covering both families with margin.
  function automatic logic in_window(input logic [3:0] code,
                                     input logic [15:0] cyc);
    logic [63:0] lo;
    logic [63:0] hi;
    lo = 64'(rate_mon_pkg::CLK_HZ) * 64'(100 - rate_mon_pkg::TOL_PCT)
         / (64'(rate_mon_pkg::fs_hz(code, 1'b0)) * 64'd100);
    hi = 64'(rate_mon_pkg::CLK_HZ) * 64'(100 + rate_mon_pkg::TOL_PCT)
         / (64'(rate_mon_pkg::fs_hz(code, 1'b1)) * 64'd100);
    return (64'(cyc) >= lo) && (64'(cyc) <= hi);
  endfunction

  function automatic logic [3:0] rate_code(input logic [15:0] cyc);
    logic [3:0] r;
    r = rate_mon_pkg::CODE_INVALID;
    for (int i = 0; i <= int'(rate_mon_pkg::RATE_CODE_MAX); i++) begin
      if (in_window(4'(i), cyc)) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] ratio_code(input logic [11:0] n);
    logic [3:0] r;
    r = rate_mon_pkg::CODE_INVALID;
    for (int i = 0; i <= int'(rate_mon_pkg::RATIO_CODE_MAX); i++) begin
      if (rate_mon_pkg::ratio_of(4'(i)) == n) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  assign prog_rate = cfg_ff[rate_mon_pkg::RATE_MSB:rate_mon_pkg::RATE_LSB];
  assign prog_ratio = cfg_ff[rate_mon_pkg::RATIO_MSB:rate_mon_pkg::RATIO_LSB];
  assign gen_en = master_select;
  assign inc64 = 64'(rate_mon_pkg::fs_hz(prog_rate, rate_family_select))
                 * 64'(rate_mon_pkg::ratio_of(prog_ratio))
                 * rate_mon_pkg::NCO_SCALE;

  // Register file.
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_rdata = rdata_ff;
    if (reg_wr && reg_addr == rate_mon_pkg::ADDR_MASTER_RATE_CONFIG) begin
      nxt_cfg = reg_wdata;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        rate_mon_pkg::ADDR_MASTER_RATE_CONFIG: nxt_rdata = cfg_ff;
        rate_mon_pkg::ADDR_MONITOR_STATUS:
          nxt_rdata = {det_rate_ff, det_ratio_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_ff <= rate_mon_pkg::MASTER_RATE_CONFIG_RST;
      rdata_ff <= 8'h00;
    end else begin
      cfg_ff <= nxt_cfg;
      rdata_ff <= nxt_rdata;
    end
  end

  // Master clock generator; an accumulator avoids integer divide error.
  always_comb begin
    nxt_acc = acc_ff;
    nxt_gcnt = gcnt_ff;
    nxt_fs_gen = fs_gen_ff;
    nxt_oe_n = ~gen_en;
    if (!gen_en || inc64 == 64'h0) begin
      nxt_acc = '0;
      nxt_gcnt = 12'h000;
      nxt_fs_gen = 1'b0;
    end else begin
      nxt_acc = acc_ff + inc64[rate_mon_pkg::ACC_W-1:0];
      if (acc_ff[rate_mon_pkg::ACC_W-1] && !nxt_acc[rate_mon_pkg::ACC_W-1])
      begin
        if (gcnt_ff + 12'h001 >= rate_mon_pkg::ratio_of(prog_ratio)) begin
          nxt_gcnt = 12'h000;
        end else begin
          nxt_gcnt = gcnt_ff + 12'h001;
        end
        nxt_fs_gen = (nxt_gcnt == 12'h000);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_ff <= '0;
      gcnt_ff <= 12'h000;
      fs_gen_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end else begin
      acc_ff <= nxt_acc;
      gcnt_ff <= nxt_gcnt;
      fs_gen_ff <= nxt_fs_gen;
      oe_n_ff <= nxt_oe_n;
    end
  end

  assign bclk_out = acc_ff[rate_mon_pkg::ACC_W-1];
  assign fsync_out = fs_gen_ff;
  assign bclk_oe_n = oe_n_ff;
  assign fsync_oe_n = oe_n_ff;

  // Pin synchronisers; stage 1 feeds stage 2, and stages 2 and 3 feed the edge detectors.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bsync_ff <= 3'h0;
      fsync_ff <= 3'h0;
    end else begin
      bsync_ff <= {bsync_ff[1:0], bclk_in};
      fsync_ff <= {fsync_ff[1:0], fsync_in};
    end
  end

  assign b_mon = bsync_ff[1];
  assign b_mon_d = bsync_ff[2];
  assign f_mon = fsync_ff[1];
  assign f_mon_d = fsync_ff[2];

  // Frame monitor.
  always_comb begin
    nxt_cyc = cyc_ff;
    nxt_bcnt = bcnt_ff;
    nxt_armed = armed_ff;
    nxt_det_rate = det_rate_ff;
    nxt_det_ratio = det_ratio_ff;
    if (cyc_ff < FRAME_TIMEOUT) begin
      nxt_cyc = cyc_ff + 16'h0001;
    end
    if (b_mon && !b_mon_d && bcnt_ff != {rate_mon_pkg::RCNT_W{1'b1}}) begin
      nxt_bcnt = bcnt_ff + 12'h001;
    end
    if (f_mon && !f_mon_d) begin
      if (armed_ff) begin
        nxt_det_rate = rate_code(cyc_ff);
        nxt_det_ratio = ratio_code(bcnt_ff);
      end
      nxt_armed = 1'b1;
      nxt_cyc = 16'h0001;
      nxt_bcnt = (b_mon && !b_mon_d) ? 12'h001 : 12'h000;
    end else if (cyc_ff >= FRAME_TIMEOUT) begin
      nxt_armed = 1'b0;
      nxt_det_rate = rate_mon_pkg::CODE_INVALID;
      nxt_det_ratio = rate_mon_pkg::CODE_INVALID;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cyc_ff <= 16'h0000;
      bcnt_ff <= 12'h000;
      armed_ff <= 1'b0;
      det_rate_ff <= rate_mon_pkg::MONITOR_STATUS_RST[7:4];
      det_ratio_ff <= rate_mon_pkg::MONITOR_STATUS_RST[3:0];
    end else begin
      cyc_ff <= nxt_cyc;
      bcnt_ff <= nxt_bcnt;
      armed_ff <= nxt_armed;
      det_rate_ff <= nxt_det_rate;
      det_ratio_ff <= nxt_det_ratio;
    end
  end

  assign reg_rdata = rdata_ff;
endmodule

// *** tb/rm_monitor.sv ***
// Purpose: Port checker for the rate monitor.
// Assumes: One core clock domain.
// Notes: Bound onto every rate_monitor instance.
`timescale 1ns/1ps
module rm_monitor #(parameter logic [15:0] FRAME_TIMEOUT = 16'hFFFF) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic master_select,
  input wire logic bclk_out,
  input wire logic bclk_oe_n,
  input wire logic fsync_out,
  input wire logic fsync_oe_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_oe_follows: assert property (!$past(rst) |->
    bclk_oe_n == !$past(master_select)) else $error("oe lag");
  chk_reset_val: assert property (disable iff (1'b0) rst |=>
    reg_rdata == 8'h00 && bclk_oe_n && fsync_oe_n) else $error("reset");
  chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("rdata moved");
  chk_unmapped_read: assert property (reg_rd && reg_addr != 8'h14 &&
    reg_addr != 8'h15 |=> reg_rdata == 8'h00) else $error("unmapped");
  chk_cfg_rw: assert property ((reg_wr && reg_addr == 8'h14) ##1
    (reg_rd && !reg_wr && reg_addr == 8'h14) |=>
    reg_rdata == $past(reg_wdata, 2)) else $error("cfg rw");
  chk_sts_codes: assert property (reg_rd && reg_addr == 8'h15 |=>
    (reg_rdata[7:4] <= 4'h8 || reg_rdata[7:4] == 4'hF) &&
    (reg_rdata[3:0] <= 4'hC || reg_rdata[3:0] == 4'hF)) else $error("code");
  chk_bclk_runs: assert property (!bclk_oe_n |-> ##[1:1000]
    bclk_out != $past(bclk_out)) else $error("bclk idle");
  chk_fs_master: assert property ($rose(fsync_out) |-> !fsync_oe_n)
    else $error("fsync slave");
endmodule
bind rate_monitor rm_monitor #(.FRAME_TIMEOUT(FRAME_TIMEOUT)) i_mon (
  .core_clk(core_clk),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_wdata(reg_wdata),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .master_select(master_select),
  .bclk_out(bclk_out),
  .bclk_oe_n(bclk_oe_n),
  .fsync_out(fsync_out),
  .fsync_oe_n(fsync_oe_n)
);

// *** tb/rm_partner.sv ***
// Purpose: Host side that drives the serial clocks.
// Assumes: Device in slave mode while run is high.
// Notes: Both lines stand low between runs, as a real host would.
`timescale 1ns/1ps
module rm_partner #(parameter int RATIO = 16, parameter int HALF_NS = 32) (
  input wire logic run,
  output logic bclk,
  output logic fsync
);
  initial begin
    {bclk, fsync} = 2'b00;
    forever begin
      wait (run);
      for (int i = 0; i < RATIO; i++) begin
        fsync = (i == 0);
        #(HALF_NS) bclk = 1'b1;
        #(HALF_NS) bclk = 1'b0;
      end
    end
  end
endmodule

// *** tb/rate_monitor_tb_top.sv ***
// Purpose: Self-checking bench for the rate monitor.
// Assumes: 200 MHz core clock, 64 ns host bit clock.
// Notes: Frame timeout is cut short to keep idle checks quick.
`timescale 1ns/1ps
module rate_monitor_tb_top;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic master_select = 1'b0, rate_family_select = 1'b0, run = 1'b0;
  logic auto_clk_cfg_off = 1'b0, bclk_out, bclk_oe_n, fsync_out;
  logic fsync_oe_n, p_bclk, p_fsync, bclk_in, fsync_in;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_v;
  int fails = 0, cmp_count = 0;
  assign bclk_in = bclk_oe_n ? p_bclk : bclk_out;
  assign fsync_in = fsync_oe_n ? p_fsync : fsync_out;
  rate_monitor #(.FRAME_TIMEOUT(16'h2000)) i_dut (
    .core_clk(core_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .master_select(master_select),
    .rate_family_select(rate_family_select),
    .auto_clk_cfg_off(auto_clk_cfg_off),
    .bclk_in(bclk_in),
    .bclk_out(bclk_out),
    .bclk_oe_n(bclk_oe_n),
    .fsync_in(fsync_in),
    .fsync_out(fsync_out),
    .fsync_oe_n(fsync_oe_n)
  );
  rm_partner i_far (.run(run), .bclk(p_bclk), .fsync(p_fsync));
  initial forever #2.5 core_clk = ~core_clk;
  task automatic finish_test();
    $display("compares %0d fails %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge core_clk);
    fails++;
    finish_test();
  end
  task automatic check(input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk) #1 reg_wr = 1'b0;
  endtask
  // Polls up to n reads, so slow frames need no fixed wait.
  task automatic rd(input logic [7:0] a, exp, input int n);
    rd_v = ~exp;
    for (int i = 0; i < n && rd_v !== exp; i++) begin
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge core_clk) #1 reg_rd = 1'b0;
      @(posedge core_clk) #1 rd_v = reg_rdata;
    end
    check(rd_v, exp);
  endtask
  // Both families share a rate code, so only the frame length tells them apart.
  task automatic frame_len(input int fs);
    int n;
    int exp;
    n = 0;
    exp = int'(rate_mon_pkg::CLK_HZ / fs);
    @(posedge fsync_out) #1;
    do begin
      @(posedge core_clk) #1;
      n++;
    end while (fsync_out);
    do begin
      @(posedge core_clk) #1;
      n++;
    end while (!fsync_out);
    check({7'h00, n >= exp - 2 && n <= exp + 2}, 8'h01);
  endtask
  task automatic t_regs();
    rd(8'h14, 8'h48, 1);
    rd(8'h15, 8'hFF, 1);
    for (int i = 0; i <= 8; i++) begin
      wr(8'h14, {4'(i), 4'(12 - i)});
      rd(8'h14, {4'(i), 4'(12 - i)}, 1);
    end
    wr(8'h15, 8'h00);
    rd(8'h15, 8'hFF, 1);
    rd(8'h16, 8'h00, 1);
    $display("register test done");
  endtask
  task automatic t_slave();
    run = 1'b1;
    rd(8'h15, 8'hF0, 12000);
    check({6'h00, bclk_oe_n, fsync_oe_n}, 8'h03);
    run = 1'b0;
    rd(8'h15, 8'hFF, 12000);
    $display("slave test done");
  endtask
  task automatic t_master();
    wr(8'h14, 8'h80);
    master_select = 1'b1;
    rd(8'h15, 8'h80, 12000);
    check({6'h00, bclk_oe_n, fsync_oe_n}, 8'h00);
    frame_len(768000);
    rate_family_select = 1'b1;
    wr(8'h14, 8'h44);
    rd(8'h15, 8'h44, 12000);
    frame_len(44100);
    $display("master test done");
  endtask
  initial begin
    #58.5 rst = 1'b0;
    #5;
    t_regs();
    t_slave();
    t_master();
    finish_test();
  end
endmodule
